/* rtl/pic_top.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RQ1: bits 4:3 pick pull mode none, down, up or repeater; reset from nvm.
// RQ2: bit 6 set inverts the pin level seen inside; resets to zero.
// RQ3: bit 10 enables emulated open-drain output drive; resets to zero.
// RQ4: filter mode 0 in bits 12:11 bypasses the filter and is the reset.
// RQ5: filter mode 1 rejects pulses shorter than one sample clock.
// RQ6: filter mode 2 rejects pulses shorter than two sample clocks.
// RQ7: filter mode 3 rejects pulses shorter than three sample clocks.
// RQ8: bits 15:13 choose one of seven divided sample clocks; reset 0.
// RQ9: software must never write the reserved clock select value 7.
// RQ10: filtered output moves only after the new level held N samples.
// RQ11: bits 2:0 and 31:16 read zero, 9:7 read 001, reserved writes ignored.
module pic_top
(
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire logic [31:0]              reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	input  wire logic [1:0]               nvm_pull_p15,
	input  wire logic [1:0]               nvm_pull_p3,
	input  wire logic [6:0]               filter_divclk,
	input  wire logic [1:0]               pad_in,
	input  wire logic [1:0]               core_out,
	input  wire logic [1:0]               core_oe,
	output logic      [1:0]               pad_out,
	output logic      [1:0]               pad_oe_n,
	output logic      [1:0]               core_in,
	output pic_pkg::pic_pad_t [1:0]       pad_ctrl
);
	// ==========================================================
	// configuration registers
	pic_pkg::pic_cfg_t [1:0] cfg_r;
	logic                    init_r;
	logic [1:0]              sel;

	// address decode shared by write and read paths
	function automatic logic [1:0] dec(input logic [31:0] a);
		dec = {a == pic_pkg::CFG_P3_ADDR, a == pic_pkg::CFG_P15_ADDR};
	endfunction : dec

	function automatic logic [31:0] pack(input pic_pkg::pic_cfg_t c);
		logic [31:0] w;
		w = 32'h0; // see RQ11
		w[pic_pkg::PULL_LSB +: 2] = c.pull;
		w[pic_pkg::HYST_BIT]      = c.hyst;
		w[pic_pkg::INVERT_BIT]    = c.invert;
		w[pic_pkg::RSV_LSB +: 3]  = pic_pkg::RSV_VAL; // see RQ11
		w[pic_pkg::PODRN_BIT]     = c.pod_en;
		w[pic_pkg::SMOD_LSB +: 2] = c.s_mode;
		w[pic_pkg::CDIV_LSB +: 3] = c.clk_div;
		pack = w;
	endfunction : pack

	assign sel = dec(reg_addr);

	// reset loads constants; the nvm pull value is caught one edge later
	// because a synchronous reset must not copy a port into a flop
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			init_r <= 1'b1;
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			begin
				cfg_r[i].pull    <= pic_pkg::PULL_NONE;
				cfg_r[i].hyst    <= pic_pkg::HYST_RST;
				cfg_r[i].invert  <= 1'b0; // see RQ2
				cfg_r[i].pod_en  <= 1'b0; // see RQ3
				cfg_r[i].s_mode  <= pic_pkg::SMOD_BYP; // see RQ4
				cfg_r[i].clk_div <= 3'h0; // see RQ8
			end
		end
		else
		begin
			init_r <= 1'b0;
			if (init_r)
			begin
				cfg_r[0].pull <= nvm_pull_p15; // see RQ1
				cfg_r[1].pull <= nvm_pull_p3;
			end
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			begin
				if (reg_wr && sel[i])
				begin
					// reserved bits are simply not stored, see RQ11
					cfg_r[i].pull    <= reg_wdata[pic_pkg::PULL_LSB +: 2];
					cfg_r[i].hyst    <= reg_wdata[pic_pkg::HYST_BIT];
					cfg_r[i].invert  <= reg_wdata[pic_pkg::INVERT_BIT];
					cfg_r[i].pod_en  <= reg_wdata[pic_pkg::PODRN_BIT];
					cfg_r[i].s_mode  <= reg_wdata[pic_pkg::SMOD_LSB +: 2];
					cfg_r[i].clk_div <= reg_wdata[pic_pkg::CDIV_LSB +: 3];
				end
			end
		end
	end

	// read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0;
		else if (reg_rd && sel[0])
			reg_rdata <= pack(cfg_r[0]);
		else if (reg_rd && sel[1])
			reg_rdata <= pack(cfg_r[1]);
		else
			reg_rdata <= 32'h0;
	end

	// ==========================================================
	// pad controls
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pad_ctrl <= '0;
		else
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			begin
				pad_ctrl[i].pull_up   <= cfg_r[i].pull == pic_pkg::PULL_UP;
				pad_ctrl[i].pull_down <= cfg_r[i].pull == pic_pkg::PULL_DOWN;
				pad_ctrl[i].repeater  <= cfg_r[i].pull == pic_pkg::PULL_RPT; // see RQ1
				pad_ctrl[i].hyst_en   <= cfg_r[i].hyst;
			end
	end

	// pseudo open-drain: only low is actively driven, a high releases the
	// pad; the push-pull driver is reused so the pad is not truly
	// open-drain and never tolerates a level above its own supply
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pad_out  <= 2'h0;
			pad_oe_n <= 2'h3;
		end
		else
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			begin
				if (cfg_r[i].pod_en)
				begin
					pad_out[i]  <= 1'b0; // see RQ3
					pad_oe_n[i] <= !(core_oe[i] && !core_out[i]);
				end
				else
				begin
					pad_out[i]  <= core_out[i];
					pad_oe_n[i] <= !core_oe[i];
				end
			end
	end

	// ==========================================================
	// input synchronisers, inversion and glitch filter
	logic [1:0] pin_s1_r, pin_s2_r, pclk_d_r;
	logic [1:0] filt_r, tick;
	logic [1:0] cnt_r [2];
	logic [6:0] dclk_s1_r, dclk_s2_r;

	// two flops on every asynchronous input before use
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pin_s1_r  <= 2'h0;
			pin_s2_r  <= 2'h0;
			dclk_s1_r <= 7'h0;
			dclk_s2_r <= 7'h0;
		end
		else
		begin
			pin_s1_r  <= pad_in;
			pin_s2_r  <= pin_s1_r;
			dclk_s1_r <= filter_divclk;
			dclk_s2_r <= dclk_s1_r;
		end
	end

	// select the sample clock and find its rising edges; 7 is unused
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pclk_d_r <= 2'h0;
		else
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
				pclk_d_r[i] <= (cfg_r[i].clk_div == pic_pkg::CDIV_RSVD) ?
					1'b0 : dclk_s2_r[cfg_r[i].clk_div]; // see RQ8, RQ9
	end

	// a tick is a rising edge of the chosen synchronised sample clock
	always_comb
	begin
		for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			tick[i] = (cfg_r[i].clk_div != pic_pkg::CDIV_RSVD) &&
				dclk_s2_r[cfg_r[i].clk_div] && !pclk_d_r[i];
	end

	// counter of consecutive samples at the new level; any sample at the
	// old level restarts it, so short pulses reach the output only in bypass mode 0
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			filt_r <= 2'h0;
			cnt_r  <= '{2'h0, 2'h0};
		end
		else
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
			begin
				if (cfg_r[i].s_mode == pic_pkg::SMOD_BYP)
				begin
					filt_r[i] <= pin_s2_r[i]; // see RQ4
					cnt_r[i]  <= 2'h0;
				end
				else if (pin_s2_r[i] == filt_r[i])
					cnt_r[i] <= 2'h0; // see RQ10
				else if (tick[i])
				begin
					if (cnt_r[i] + 2'h1 >= cfg_r[i].s_mode)
					begin
						filt_r[i] <= pin_s2_r[i]; // see RQ5, RQ6, RQ7
						cnt_r[i]  <= 2'h0;
					end
					else
						cnt_r[i] <= cnt_r[i] + 2'h1;
				end
			end
	end

	// inversion applied after filtering, towards the peripherals
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			core_in <= 2'h0;
		else
			for (int i = 0; i < pic_pkg::NUM_PINS; i++)
				core_in[i] <= filt_r[i] ^ cfg_r[i].invert; // see RQ2
	end

	// ==========================================================
	// checks
	chk_invert_path: assert property (@(posedge core_clk) // see RQ2
		disable iff (!rst_n)
		core_in[0] == ($past(filt_r[0]) ^ $past(cfg_r[0].invert)))
		else $error("inversion mismatch");
	chk_invert_p3: assert property (@(posedge core_clk) // see RQ2
		disable iff (!rst_n)
		core_in[1] == ($past(filt_r[1]) ^ $past(cfg_r[1].invert)))
		else $error("inversion mismatch on second pin");
	chk_pod_high: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(cfg_r[0].pod_en) |-> pad_out[0] == 1'b0) // see RQ3
		else $error("pseudo drain drives high");
	chk_pod_release: assert property (@(posedge core_clk) // see RQ3
		disable iff (!rst_n)
		$past(cfg_r[1].pod_en) |-> pad_oe_n[1] ==
		!($past(core_oe[1]) && !$past(core_out[1])))
		else $error("pseudo drain enable wrong");
	chk_nvm_load: assert property (@(posedge core_clk) // see RQ1
		disable iff (!rst_n)
		init_r |=> cfg_r[0].pull == $past(nvm_pull_p15) ||
		$past(reg_wr && sel[0]))
		else $error("nonvolatile pull not loaded");
	chk_bypass: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg_r[0].s_mode == 2'h0 |=> filt_r[0] == $past(pin_s2_r[0])) // see RQ4
		else $error("bypass not transparent");
	chk_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg_r[0].s_mode != 2'h0 && !tick[0] && $stable(cfg_r[0].s_mode))
		|=> $stable(filt_r[0])) // see RQ10
		else $error("filter moved without sample");
	chk_mode1: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg_r[0].s_mode == 2'h1 && tick[0] && pin_s2_r[0] != filt_r[0])
		|=> filt_r[0] == $past(pin_s2_r[0])) // see RQ5
		else $error("mode 1 missed change");
	chk_mode3: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cfg_r[0].s_mode == 2'h3 && tick[0] && cnt_r[0] == 2'h0 &&
		pin_s2_r[0] != filt_r[0]) |=> $stable(filt_r[0])) // see RQ7
		else $error("long mode took one sample");
	chk_rsvd_read: assert property (@(posedge core_clk) // see RQ11
		disable iff (!rst_n)
		$past(reg_rd) |-> reg_rdata[2:0] == 3'h0 && reg_rdata[31:16] == 16'h0)
		else $error("reserved bits nonzero");
	chk_rsvd_one: assert property (@(posedge core_clk) disable iff (!rst_n)
		$past(reg_rd && sel[1]) |-> reg_rdata[9:7] == 3'h1) // see RQ11
		else $error("reserved 9:7 wrong");
	chk_write_cfg: assert property (@(posedge core_clk) // see RQ1, RQ8
		disable iff (!rst_n)
		(reg_wr && sel[0] && !init_r) |=> cfg_r[0].clk_div ==
		$past(reg_wdata[15:13]) && cfg_r[0].pull == $past(reg_wdata[4:3]))
		else $error("write lost");
	cov_pod: cover property (@(posedge core_clk)
		cfg_r[0].pod_en && !pad_oe_n[0]);
	cov_filt2: cover property (@(posedge core_clk)
		cfg_r[0].s_mode == 2'h2 && $changed(filt_r[0]));
	cov_filt3: cover property (@(posedge core_clk)
		cfg_r[0].s_mode == 2'h3 && $changed(filt_r[0]));
	cov_invert: cover property (@(posedge core_clk)
		cfg_r[0].invert && core_in[0]);
endmodule : pic_top

/* rtl/pic_pkg.sv */
package pic_pkg;
	// ==========================================================
	// register map, byte addresses
	localparam logic [31:0] CFG_P15_ADDR  = 32'h400440a0;
	localparam logic [31:0] CFG_P3_ADDR   = 32'h400440a4;
	// ==========================================================
	// field positions and widths
	localparam int PULL_LSB = 3;
	localparam int HYST_BIT   = 5;
	localparam int INVERT_BIT = 6;
	localparam int RSV_LSB    = 7;
	localparam int PODRN_BIT  = 10;
	localparam int SMOD_LSB = 11;
	localparam int CDIV_LSB = 13;
	// ==========================================================
	// reset values and encodings
	localparam logic [2:0] RSV_VAL    = 3'h1;
	localparam logic       HYST_RST   = 1'h1;
	localparam logic [1:0] SMOD_BYP   = 2'h0;
	localparam logic [2:0] CDIV_RSVD  = 3'h7;
	localparam int         NUM_DIVCLK = 7;
	localparam int         NUM_PINS   = 2;
	localparam logic [1:0] PULL_NONE  = 2'h0;
	localparam logic [1:0] PULL_DOWN  = 2'h1;
	localparam logic [1:0] PULL_UP    = 2'h2;
	localparam logic [1:0] PULL_RPT   = 2'h3;

	// per pin configuration fields
	typedef struct packed {
		logic [2:0] clk_div;
		logic [1:0] s_mode;
		logic       pod_en;
		logic       invert;
		logic       hyst;
		logic [1:0] pull;
	} pic_cfg_t;

	// pad control bundle sent towards one pad
	typedef struct packed {
		logic pull_up;
		logic pull_down;
		logic repeater;
		logic hyst_en;
	} pic_pad_t;
endpackage : pic_pkg

/* tb/pic_pad_model.sv */
`timescale 1ns/1ps
// ====================================================================
// pins and shared divided sample clocks seen by the block
module pic_pad_model
(
	input  wire logic                    core_clk,
	input  wire logic [1:0]              ext_en,
	input  wire logic [1:0]              ext_lvl,
	input  wire logic [1:0]              pad_out,
	input  wire logic [1:0]              pad_oe_n,
	input  wire pic_pkg::pic_pad_t [1:0] pad_ctrl,
	output logic      [6:0]              filter_divclk,
	output logic      [1:0]              pad_in
);
	logic [7:0] div_r = 8'h00;
	logic       tog_r = 1'b0;

	// clock k has a period of 2^(k+1) core cycles
	always_ff @(posedge core_clk)
	begin
		div_r <= div_r + 8'h01;
		tog_r <= ~tog_r;
	end
	assign filter_divclk = div_r[6:0];

	// own drive wins, then the far driver, then the pulls; a floating
	// pin toggles so that no level is read by luck
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (!pad_oe_n[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_lvl[i];
			else if (pad_ctrl[i].pull_up)
				pad_in[i] = 1'b1;
			else if (pad_ctrl[i].pull_down)
				pad_in[i] = 1'b0;
			else
				pad_in[i] = tog_r;
		end
	end
endmodule : pic_pad_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] A15 = pic_pkg::CFG_P15_ADDR;
	localparam logic [31:0] A3  = pic_pkg::CFG_P3_ADDR;
	logic                    core_clk, rst_n, reg_wr, reg_rd, hi;
	logic [31:0]             reg_addr, reg_wdata, reg_rdata;
	logic [6:0]              filter_divclk;
	logic [1:0]              pad_in, core_out, core_oe, pad_out;
	logic [1:0]              pad_oe_n, core_in, ext_lvl;
	pic_pkg::pic_pad_t [1:0] pad_ctrl;
	int                      fail_count, n_tests, cyc;
	// mode, clock select, pulse length, passes; short pulses must die except in mode 0
	int ft [7][4] = '{'{0,0,2,1}, '{1,1,8,1}, '{2,1,4,0}, '{2,1,12,1},
		'{3,1,8,0}, '{3,1,16,1}, '{3,2,16,0}};

	pic_top pic_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_pull_p15(2'h2),
		.nvm_pull_p3(2'h1), .filter_divclk(filter_divclk),
		.pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
		.pad_out(pad_out), .pad_oe_n(pad_oe_n), .core_in(core_in),
		.pad_ctrl(pad_ctrl));
	pic_pad_model pic_pad_model_i (.core_clk(core_clk), .ext_en(2'h1),
		.ext_lvl(ext_lvl), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pad_ctrl(pad_ctrl), .filter_divclk(filter_divclk),
		.pad_in(pad_in));

	// ================================================================
	// clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fail_count++;
			results();
		end
	end

	// ================================================================
	// access tasks; wr, rdchk, tick and pin start at a rising edge
	task check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rdchk(input logic [31:0] a, input logic [31:0] exp, string nm);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		check(nm, reg_rdata, exp);
	endtask : rdchk
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : tick
	task pin(input logic v);
		@(posedge core_clk);
		ext_lvl <= {1'b0, v};
	endtask : pin
	task results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// ================================================================
	// main sequence
	initial
	begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{core_out, core_oe, ext_lvl, fail_count, n_tests, cyc} = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		tick(2);
		rdchk(A15, 32'h000000b0, "p15 reset");
		rdchk(A3, 32'h000000a8, "p3 reset");
		check("ctl reset", {28'h0, pad_ctrl[0]}, 32'h9);
		check("ctl p3", {28'h0, pad_ctrl[1]}, 32'h5);
		check("p3 in", {31'h0, core_in[1]}, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			wr(A15, 32'h20 | (m << 3));
			tick(2);
			check("pull", {28'h0, pad_ctrl[0]},
				{m == 2, m == 1, m == 3, 1'b1});
		end
		// unmapped writes land nowhere, reserved bits hold their values
		wr(32'h400440a8, 32'hffffffff);
		rdchk(32'h400440a8, 32'h0, "unmapped");
		rdchk(A3, 32'h000000a8, "p3 kept");
		wr(A15, 32'hffffdfff);
		rdchk(A15, 32'h0000dcf8, "all ones");
		for (int k = 0; k < 4; k++)
		begin
			wr(A15, 32'h20 | (k[1] << 6));
			pin(k[0]);
			tick(6);
			check("invert", core_in[0], k[0] ^ k[1]);
		end
		for (int t = 0; t < 7; t++)
		begin
			wr(A15, 32'h20 | (ft[t][0] << 11) | (ft[t][1] << 13));
			pin(1'b0);
			tick(60);
			pin(1'b1);
			repeat (ft[t][2] - 1) @(posedge core_clk);
			ext_lvl <= 2'h0;
			hi = 1'b0;
			repeat (60)
			begin
				@(negedge core_clk);
				hi = hi | core_in[0];
			end
			check("filter", hi, ft[t][3]);
		end
		// emulated open drain only ever drives low
		for (int k = 0; k < 4; k++)
		begin
			wr(A15, 32'h20 | (k[1] << 10));
			@(posedge core_clk);
			core_oe <= 2'h1;
			core_out <= {1'b0, k[0]};
			tick(3);
			check("drive", {pad_out[0], pad_oe_n[0]},
				{k[0] & ~k[1], k[0] & k[1]});
		end
		results();
	end
endmodule : tb_top
